// file: hdl/gdac_pkg.sv
// Shared constants for the gamma DAC serial control link and its master.
package gdac_pkg;
	localparam int NCH = 24;
	localparam int CHW = 10;
	localparam logic [5:0] DEV_ADDR_HI = 6'h3a;
	localparam logic [7:0] GC_ADDR = 8'h00;
	localparam logic [7:0] GC_RESET = 8'h06;
	localparam logic [4:0] HS_CODE = 5'h01;
	localparam logic [9:0] MIDSCALE = 10'h200;
	localparam logic [5:0] MAX_CH = 6'h17;
	localparam logic [4:0] NV_MAX_WR = 5'h10;
	localparam logic [1:0] PM_WRITE = 2'h0;
	localparam logic [1:0] PM_SINGLE = 2'h1;
	localparam logic [1:0] PM_GEN = 2'h2;
	localparam int UPD_BIT = 7;
	localparam logic [2:0] PWR_WAIT = 3'h4;
	localparam int CLK_MHZ = 100;
	localparam int GEN_ACQ_US = 750;
	localparam int SINGLE_ACQ_US = 36;
	localparam int GEN_ACQ_CYC = GEN_ACQ_US * CLK_MHZ;
	localparam int SINGLE_ACQ_CYC = SINGLE_ACQ_US * CLK_MHZ;
	localparam int TMR_W = 20;
	localparam int STD_KHZ = 400;
	localparam int HS_KHZ = 3400;
	localparam int HALF_STD = (CLK_MHZ * 1000 + 2 * STD_KHZ - 1) / (2 * STD_KHZ);
	localparam int HALF_HS = (CLK_MHZ * 1000 + 2 * HS_KHZ - 1) / (2 * HS_KHZ);
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_TXD = 8'h04;
	localparam logic [7:0] REG_RXD = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam logic [2:0] OP_START = 3'h1;
	localparam logic [2:0] OP_STOP = 3'h2;
	localparam logic [2:0] OP_WRITE = 3'h3;
	localparam logic [2:0] OP_READ = 3'h4;
	localparam int CMD_ACK_BIT = 8;
endpackage : gdac_pkg

// file: hdl/gdac_if.sv
// Two-wire link between the master and the DAC control device, with wired-and resolution.
`timescale 1ns/1ps
`default_nettype none
interface gdac_if;
	logic scl_o;
	logic scl_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic scl;
	logic sda;
	// Open-drain lines with pull-ups: a line is low only while some end drives a zero.
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
	modport host (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
		input scl, input sda);
	modport dev (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : gdac_if
`default_nettype wire

// file: hdl/gdac_sync.sv
// Three-stage input synchroniser whose output moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module gdac_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic [W-1:0] d_i, // asynchronous inputs
	output logic [W-1:0] q_o // filtered, synchronised levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} gdac_sync_s;
	gdac_sync_s q, d;
	always_comb begin
		d = q;
		d.s1 = d_i;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < W; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.q[i] = q.s3[i];
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
		end else begin
			q <= d;
		end
	end
	assign q_o = q.q;
endmodule : gdac_sync
`default_nettype wire

// file: hdl/gdac_dev.sv
// Slave-side control logic of the 24-channel gamma DAC: link decode, registers, banks, acquires.
// Contract
// - Match address 111010 plus address select pin.
// - Master sends 00001xxx after START, slow clock.
// - Master code: no acknowledge, enter fast mode.
// - Fast mode persists over repeated START, ends at STOP.
// - General call 00h then 06h: full reset.
// - Always ack 00h; nack other call data.
// - Power-up loads stored values, unprogrammed gets midscale.
// - Channel register separate from output latch.
// - Data bit 15 set copies word to output.
// - Final word with bit 15 updates all outputs.
// - Bank pin low first bank, high second.
// - Bank pin change reloads all from new bank.
// - Each bank accepts at most 16 rewrites; the code limits each channel of a bank to 16 writes.
// - Acquires read the currently selected bank.
// - Master keeps bank pin stable 1 ms first.
// - General acquire pointer 10 plus valid channel.
// - General acquire loads everything after 750 us.
// - Single acquire pointer 01 plus valid channel.
// - Single acquire loads one channel after 36 us.
// - Pointer 00 selects channel for write/read.
// - Device never drives the clock line.
`timescale 1ns/1ps
`default_nettype none
module gdac_dev #(
	parameter int GEN_ACQ_CYC = gdac_pkg::GEN_ACQ_CYC
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // synchronous reset, high
	gdac_if.dev link, // two-wire link, data line only driven
	input wire logic address_select_pin_i, // low bit of the slave address
	input wire logic memory_bank_select_pin_i, // low first bank, high second bank
	input wire logic nv_wr_i, // program one stored word, one cycle
	input wire logic nv_bank_i, // bank to program
	input wire logic [4:0] nv_ch_i, // channel to program
	input wire logic [9:0] nv_data_i, // word to program
	output logic [gdac_pkg::NCH-1:0][9:0] dac_out_o, // output latches driving the DACs
	output logic hs_mode_o, // high-speed filters enabled
	output logic acq_busy_o // an acquire is waiting to land
);
	typedef enum logic [8:0] {
		P_IDLE = 9'h001, P_ADDR = 9'h002, P_PTR = 9'h004, P_MSB = 9'h008, P_LSB = 9'h010,
		P_GC = 9'h020, P_GCA = 9'h040, P_RD = 9'h080, P_IGN = 9'h100
	} gdac_ph_e;
	typedef enum logic [2:0] {
		A_NONE = 3'h1, A_GEN = 3'h2, A_ONE = 3'h4
	} gdac_acq_e;
	typedef struct packed {
		gdac_ph_e ph;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic ack;
		logic sda_low;
		logic [5:0] ptr;
		logic half;
		logic [7:0] msb;
		logic [7:0] tx;
		logic hs;
		gdac_acq_e pend;
		logic [5:0] pch;
		logic scl_p;
		logic sda_p;
		gdac_acq_e akind;
		logic [5:0] ach;
		logic [gdac_pkg::TMR_W-1:0] atmr;
		logic [2:0] pu;
		logic bank;
		logic [gdac_pkg::NCH-1:0][9:0] regs;
		logic [gdac_pkg::NCH-1:0][9:0] outs;
		logic [1:0][gdac_pkg::NCH-1:0][9:0] nv;
		logic [1:0][gdac_pkg::NCH-1:0][4:0] nvn;
	} gdac_dev_s;

	gdac_dev_s q, d;
	logic scl_s, sda_s, a0_s, bank_s;
	logic scl_rise, scl_fall, start_c, stop_c, ld_all, ld_one, valid;
	logic [7:0] byte_w;
	logic [9:0] w;

	function automatic gdac_dev_s rst_val();
		gdac_dev_s r;
		r = '0;
		r.ph = P_IDLE;
		r.pend = A_NONE;
		r.akind = A_NONE;
		r.scl_p = 1'b1;
		r.sda_p = 1'b1;
		r.pu = gdac_pkg::PWR_WAIT;
		return r;
	endfunction : rst_val

	function automatic logic [7:0] rd_byte(input gdac_dev_s s, input logic [5:0] p,
		input logic lo);
		logic [9:0] v;
		v = (p <= gdac_pkg::MAX_CH) ? s.regs[p[4:0]] : 10'h000;
		return lo ? v[7:0] : {6'h00, v[9:8]};
	endfunction : rd_byte

	gdac_sync #(.W(4), .INIT(4'h3)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({memory_bank_select_pin_i, address_select_pin_i, link.sda, link.scl}),
		.q_o({bank_s, a0_s, sda_s, scl_s})
	);

	assign scl_rise = scl_s && !q.scl_p;
	assign scl_fall = !scl_s && q.scl_p;
	assign start_c = q.scl_p && scl_s && q.sda_p && !sda_s;
	assign stop_c = q.scl_p && scl_s && !q.sda_p && sda_s;
	assign byte_w = {q.sh[6:0], sda_s};

	always_comb begin
		d = q;
		d.scl_p = scl_s;
		d.sda_p = sda_s;
		ld_all = 1'b0;
		ld_one = 1'b0;
		valid = (byte_w[5:0] <= gdac_pkg::MAX_CH);
		w = '0;
		// Stored words load the channels; the power-up wait lets the pin filter settle.
		if (q.pu != 3'h0) begin
			d.pu = q.pu - 3'h1;
			ld_all = (q.pu == 3'h1);
			d.bank = bank_s;
		end else if (bank_s != q.bank) begin
			d.bank = bank_s;
			ld_all = 1'b1;
		end else if (q.akind != A_NONE) begin
			if (q.atmr == '0) begin
				ld_all = (q.akind == A_GEN);
				ld_one = (q.akind == A_ONE);
				d.akind = A_NONE;
			end else begin
				d.atmr = q.atmr - 1'b1;
			end
		end
		for (int i = 0; i < gdac_pkg::NCH; i++) begin
			w = (q.nvn[bank_s][i] == 5'h00) ? gdac_pkg::MIDSCALE : q.nv[bank_s][i];
			if (ld_all || (ld_one && q.ach == 6'(i))) begin
				d.regs[i] = w;
				d.outs[i] = w;
			end
		end
		if (nv_wr_i && nv_ch_i <= gdac_pkg::MAX_CH[4:0]
			&& q.nvn[nv_bank_i][nv_ch_i] != gdac_pkg::NV_MAX_WR) begin
			d.nv[nv_bank_i][nv_ch_i] = nv_data_i;
			d.nvn[nv_bank_i][nv_ch_i] = q.nvn[nv_bank_i][nv_ch_i] + 5'h01;
		end
		if (start_c) begin
			d.ph = P_ADDR;
			d.cnt = 4'h0;
			d.ack = 1'b0;
			d.sda_low = 1'b0;
			d.pend = A_NONE;
		end else if (stop_c) begin
			d.ph = P_IDLE;
			d.ack = 1'b0;
			d.sda_low = 1'b0;
			d.hs = 1'b0;
			d.pend = A_NONE;
			if (q.pend != A_NONE) begin
				d.akind = q.pend;
				d.ach = q.pch;
				d.atmr = (q.pend == A_GEN) ? gdac_pkg::TMR_W'(GEN_ACQ_CYC - 1)
					: gdac_pkg::TMR_W'(gdac_pkg::SINGLE_ACQ_CYC - 1);
			end
		end else if (scl_rise && q.ph != P_IDLE) begin
			if (q.cnt < 4'h8) begin
				d.sh = byte_w;
				d.cnt = q.cnt + 4'h1;
				if (q.cnt == 4'h7) begin
					unique case (q.ph)
						P_ADDR: begin
							if (byte_w[7:1] == {gdac_pkg::DEV_ADDR_HI, a0_s}) begin
								d.ack = 1'b1;
								d.ph = byte_w[0] ? P_RD : P_PTR;
								d.half = 1'b0;
								d.tx = rd_byte(q, q.ptr, 1'b0);
							end else if (byte_w == gdac_pkg::GC_ADDR) begin
								d.ack = 1'b1;
								d.ph = P_GC;
							end else begin
								d.hs = q.hs || (byte_w[7:3] == gdac_pkg::HS_CODE);
								d.ph = P_IGN;
							end
						end
						P_PTR: begin
							d.ack = valid;
							d.ph = P_IGN;
							if (valid && byte_w[7:6] == gdac_pkg::PM_WRITE) begin
								d.ptr = byte_w[5:0];
								d.ph = P_MSB;
							end else if (valid && byte_w[7:6] == gdac_pkg::PM_GEN) begin
								d.pend = A_GEN;
								d.pch = byte_w[5:0];
							end else if (valid && byte_w[7:6] == gdac_pkg::PM_SINGLE) begin
								d.pend = A_ONE;
								d.pch = byte_w[5:0];
							end else begin
								d.ack = 1'b0;
							end
						end
						P_MSB: begin
							d.ack = 1'b1;
							d.msb = byte_w;
							d.ph = P_LSB;
						end
						P_LSB: begin
							d.ack = 1'b1;
							d.ph = P_MSB;
							d.ptr = q.ptr + 6'h01;
							if (q.ptr <= gdac_pkg::MAX_CH) begin
								d.regs[q.ptr[4:0]] = {q.msb[1:0], byte_w};
							end
							if (q.msb[gdac_pkg::UPD_BIT]) begin
								d.outs = d.regs;
							end
						end
						P_GC: begin
							d.ack = (byte_w == gdac_pkg::GC_RESET);
							d.ph = d.ack ? P_GCA : P_IGN;
						end
						default: begin
							d.ack = 1'b0;
						end
					endcase
				end
			end else if (q.cnt == 4'h8) begin
				d.cnt = 4'h9;
				if (q.ph == P_RD && !q.ack) begin
					if (sda_s) begin
						d.ph = P_IGN;
					end else begin
						d.half = !q.half;
						d.ptr = q.half ? q.ptr + 6'h01 : q.ptr;
						d.tx = rd_byte(q, d.ptr, !q.half);
					end
				end
			end
		end else if (scl_fall && q.ph != P_IDLE) begin
			if (q.cnt == 4'h8) begin
				d.sda_low = q.ack;
			end else if (q.cnt == 4'h9) begin
				d.cnt = 4'h0;
				d.ack = 1'b0;
				d.sda_low = (q.ph == P_RD) && !q.tx[7];
				d.tx = {q.tx[6:0], 1'b0};
				if (q.ph == P_GCA) begin
					d = rst_val();
					d.nv = q.nv;
					d.nvn = q.nvn;
				end
			end else if (q.ph == P_RD && q.cnt != 4'h0) begin
				d.sda_low = !q.tx[7];
				d.tx = {q.tx[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= rst_val();
		end else begin
			q <= d;
		end
	end

	assign link.sda_s_o = 1'b0;
	assign link.sda_s_oe = q.sda_low;
	assign dac_out_o = q.outs;
	assign hs_mode_o = q.hs;
	assign acq_busy_o = (q.akind != A_NONE);
endmodule : gdac_dev
`default_nettype wire

// file: hdl/gdac_host.sv
// Bus master end: byte-level link engine driven by a small register port.
`timescale 1ns/1ps
`default_nettype none
module gdac_host #(
	parameter int HALF_STD = gdac_pkg::HALF_STD,
	parameter int HALF_HS = gdac_pkg::HALF_HS
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // synchronous reset, high
	gdac_if.host link, // two-wire link, clock and data driven
	input wire logic [7:0] addr_i, // register byte address
	input wire logic [31:0] wdata_i, // write data
	input wire logic wr_i, // write strobe, one cycle
	input wire logic rd_i, // read strobe, one cycle
	output logic [31:0] rdata_o // read data, the cycle after rd_i
);
	typedef enum logic [3:0] {
		H_IDLE = 4'h1, H_START = 4'h2, H_STOP = 4'h4, H_XFER = 4'h8
	} gdac_hst_e;
	typedef struct packed {
		gdac_hst_e st;
		logic [1:0] step;
		logic [3:0] bitn;
		logic [7:0] div;
		logic [8:0] ob;
		logic [8:0] ib;
		logic [7:0] txd;
		logic [7:0] rxd;
		logic ack;
		logic scl_low;
		logic sda_low;
		logic hs;
		logic first;
		logic [31:0] rdata;
	} gdac_hst_s;

	gdac_hst_s q, d;
	logic sda_s, tick;
	logic [7:0] half;

	gdac_sync #(.W(1), .INIT(1'b1)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(link.sda),
		.q_o(sda_s)
	);

	assign half = q.hs ? 8'(HALF_HS - 1) : 8'(HALF_STD - 1);
	assign tick = (q.div == half);

	always_comb begin
		d = q;
		d.rdata = '0;
		d.div = (q.st == H_IDLE || tick) ? 8'h00 : q.div + 8'h01;
		unique case (q.st)
			H_IDLE: begin
				if (wr_i && addr_i == gdac_pkg::REG_CMD) begin
					d.step = 2'h0;
					d.bitn = 4'h0;
					if (wdata_i[2:0] == gdac_pkg::OP_START) begin
						d.st = H_START;
					end else if (wdata_i[2:0] == gdac_pkg::OP_STOP) begin
						d.st = H_STOP;
					end else if (wdata_i[2:0] == gdac_pkg::OP_WRITE) begin
						d.st = H_XFER;
						d.ob = {q.txd, 1'b1};
					end else if (wdata_i[2:0] == gdac_pkg::OP_READ) begin
						d.st = H_XFER;
						d.ob = {8'hff, !wdata_i[gdac_pkg::CMD_ACK_BIT]};
					end
				end
			end
			H_START: begin
				if (tick) begin
					d.step = q.step + 2'h1;
					unique case (q.step)
						2'h0: d.sda_low = 1'b0;
						2'h1: d.scl_low = 1'b0;
						2'h2: d.sda_low = 1'b1;
						2'h3: begin
							d.scl_low = 1'b1;
							d.first = 1'b1;
							d.st = H_IDLE;
						end
					endcase
				end
			end
			H_STOP: begin
				if (tick) begin
					d.step = q.step + 2'h1;
					if (q.step == 2'h0) begin
						d.sda_low = 1'b1;
					end else if (q.step == 2'h1) begin
						d.scl_low = 1'b0;
					end else begin
						d.sda_low = 1'b0;
						d.hs = 1'b0;
						d.st = H_IDLE;
					end
				end
			end
			H_XFER: begin
				if (tick) begin
					d.step = q.step + 2'h1;
					if (q.step == 2'h0) begin
						d.sda_low = !q.ob[8];
					end else if (q.step == 2'h1) begin
						d.scl_low = 1'b0;
					end else begin
						d.scl_low = 1'b1;
						d.step = 2'h0;
						d.ib = {q.ib[7:0], sda_s};
						d.ob = {q.ob[7:0], 1'b1};
						d.bitn = q.bitn + 4'h1;
						if (q.bitn == 4'h8) begin
							d.sda_low = 1'b0;
							d.rxd = q.ib[7:0];
							d.ack = !sda_s;
							d.first = 1'b0;
							d.st = H_IDLE;
							// The code byte goes out slowly; the link speeds up after it.
							if (q.first && q.txd[7:3] == gdac_pkg::HS_CODE && q.ib[7:3] == gdac_pkg::HS_CODE) begin
								d.hs = 1'b1;
							end
						end
					end
				end
			end
			default: begin
				d.st = H_IDLE;
			end
		endcase
		if (wr_i && addr_i == gdac_pkg::REG_TXD) begin
			d.txd = wdata_i[7:0];
		end
		if (rd_i) begin
			if (addr_i == gdac_pkg::REG_RXD) begin
				d.rdata = {24'h000000, q.rxd};
			end else if (addr_i == gdac_pkg::REG_STAT) begin
				d.rdata = {29'h00000000, q.hs, q.ack, q.st != H_IDLE};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '{st: H_IDLE, default: '0};
		end else begin
			q <= d;
		end
	end

	assign link.scl_o = 1'b0;
	assign link.scl_oe = q.scl_low;
	assign link.sda_m_o = 1'b0;
	assign link.sda_m_oe = q.sda_low;
	assign rdata_o = q.rdata;
endmodule : gdac_host
`default_nettype wire

// file: dv/gdac_props.sv
// Link and status checks between the host and the DAC control device.
`timescale 1ns/1ps
`default_nettype none
module gdac_props #(
	parameter int GEN_ACQ_CYC = gdac_pkg::GEN_ACQ_CYC
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic scl_o, // host clock level
	input wire logic scl_oe, // host clock enable
	input wire logic sda_s_oe, // device data enable
	input wire logic scl, // resolved clock
	input wire logic sda, // resolved data
	input wire logic hs_mode_o, // device fast mode
	input wire logic acq_busy_o // acquire pending
);
	localparam int SGL = gdac_pkg::SINGLE_ACQ_CYC;
	int busy_q;
	int hs_q;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Saturates so that later fast transfers are not judged as the code's own slot.
	always_ff @(posedge clk_i) begin
		busy_q <= (rst_i || !acq_busy_o) ? 0 : busy_q + 1;
		hs_q <= rst_i ? 200 : $rose(hs_mode_o) ? 0 : (hs_q < 200 ? hs_q + 1 : 200);
	end
	a_scl_host_only: assert property (!scl |-> scl_oe && !scl_o)
		else $error("clock low while the host is not driving it");
	a_ack_low_clk: assert property ($rose(sda_s_oe) |-> !scl)
		else $error("device took data line while clock high");
	a_sda_stable_high: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
		else $error("device moved data line during high clock");
	a_ack_released: assert property ($rose(sda_s_oe) |-> ##[1:600] !sda_s_oe)
		else $error("device held data line too long");
	a_hs_nack: assert property (hs_mode_o && hs_q < 60 |-> !sda_s_oe)
		else $error("master code was acknowledged");
	a_hs_end_stop: assert property ($fell(hs_mode_o) |-> scl && sda)
		else $error("fast mode left without a stop");
	a_busy_at_stop: assert property ($rose(acq_busy_o) |-> scl && sda)
		else $error("acquire began before the stop");
	a_acq_length: assert property ($fell(acq_busy_o) |->
		busy_q inside {[GEN_ACQ_CYC - 3:GEN_ACQ_CYC + 3], [SGL - 3:SGL + 3]})
		else $error("acquire wait has the wrong length");
	c_hs: cover property ($rose(hs_mode_o));
	c_hs_end: cover property ($fell(hs_mode_o));
	c_acq: cover property ($fell(acq_busy_o));
	c_ack: cover property ($rose(sda_s_oe));
endmodule : gdac_props
`default_nettype wire

// file: dv/gamma_dac_i2c_control_bench.sv
// Self-checking bench: the host port drives the link into the DAC control device.
`timescale 1ns/1ps
`default_nettype none
module gamma_dac_i2c_control_bench;
	localparam int GEN = 200;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic a0 = 1'b0;
	logic bank = 1'b0;
	logic nv_wr = 1'b0;
	logic nv_bk = 1'b0;
	logic [4:0] nv_ch = 5'h00;
	logic [9:0] nv_d = 10'h000;
	logic [gdac_pkg::NCH-1:0][9:0] dac;
	logic hs;
	logic busy;
	logic rd_chk = 1'b0;
	logic rd_seen = 1'b0;
	logic look = 1'b0;
	logic ehs = 1'b0;
	int look_sel = 0;
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	logic [31:0] exp_q[$];
	logic [31:0] last_rd;
	logic [31:0] seen;
	logic [9:0] v0;
	logic [9:0] v1;
	logic [9:0] v5;
	logic [7:0] bad [3] = '{8'h98, 8'h58, 8'hc0};
	always #5 clk_i = ~clk_i;
	gdac_if lnk();
	gdac_host #(.HALF_STD(20), .HALF_HS(8)) gdac_host_i (.clk_i(clk_i), .rst_i(rst_i),
		.link(lnk), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o));
	gdac_dev #(.GEN_ACQ_CYC(GEN)) gdac_dev_i (.clk_i(clk_i), .rst_i(rst_i), .link(lnk),
		.address_select_pin_i(a0), .memory_bank_select_pin_i(bank), .nv_wr_i(nv_wr),
		.nv_bank_i(nv_bk), .nv_ch_i(nv_ch), .nv_data_i(nv_d), .dac_out_o(dac),
		.hs_mode_o(hs), .acq_busy_o(busy));
	gdac_props #(.GEN_ACQ_CYC(GEN)) gdac_props_i (.clk_i(clk_i), .rst_i(rst_i),
		.scl_o(lnk.scl_o), .scl_oe(lnk.scl_oe), .sda_s_oe(lnk.sda_s_oe), .scl(lnk.scl),
		.sda(lnk.sda), .hs_mode_o(hs), .acq_busy_o(busy));
	always @(posedge clk_i) begin
		rd_seen <= rd_i && rd_chk;
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			failures++;
			wrap_up();
		end
	end
	// Compared on the falling edge, where read data and outputs are settled.
	always @(negedge clk_i) begin
		if (rd_seen || look) begin
			seen = !look ? rdata_o : look_sel < 24 ? {22'h0, dac[look_sel]} :
				look_sel == 24 ? {31'h0, hs} : {31'h0, busy};
			check(seen, exp_q.pop_front());
		end
	end
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : check
	task automatic wrap_up();
		if (failures == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		rd_chk <= c;
		if (c) exp_q.push_back(e);
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		last_rd = rdata_o;
		@(posedge clk_i);
	endtask : rd
	task automatic see(input int s, input logic [31:0] e);
		look_sel = s;
		look <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_i);
		look <= 1'b0;
		@(posedge clk_i);
	endtask : see
	task automatic nvp(input logic b, input logic [4:0] c, input logic [9:0] d);
		nv_bk <= b;
		nv_ch <= c;
		nv_d <= d;
		nv_wr <= 1'b1;
		@(posedge clk_i);
		nv_wr <= 1'b0;
		@(posedge clk_i);
	endtask : nvp
	task automatic xfer(input logic [2:0] o, input logic [7:0] tx, input logic mack);
		int n;
		n = 0;
		wr(gdac_pkg::REG_TXD, {24'h0, tx});
		wr(gdac_pkg::REG_CMD, {23'h0, mack, 5'h0, o});
		do begin
			rd(gdac_pkg::REG_STAT, 1'b0, 32'h0);
			n++;
		end while (last_rd[0] && n < 2000);
		if (last_rd[0]) begin
			failures++;
			wrap_up();
		end
	endtask : xfer
	task automatic sb(input logic [7:0] b, input logic ack);
		xfer(gdac_pkg::OP_WRITE, b, 1'b0);
		rd(gdac_pkg::REG_STAT, 1'b1, {29'h0, ehs, ack, 1'b0});
	endtask : sb
	task automatic rb(input logic mack, input logic [7:0] e);
		xfer(gdac_pkg::OP_READ, 8'h00, mack);
		rd(gdac_pkg::REG_RXD, 1'b1, {24'h0, e});
	endtask : rb
	task automatic st();
		xfer(gdac_pkg::OP_START, 8'h00, 1'b0);
	endtask : st
	task automatic sp();
		xfer(gdac_pkg::OP_STOP, 8'h00, 1'b0);
		repeat (20) @(posedge clk_i);
	endtask : sp
	function automatic logic [7:0] aw(input logic r);
		return {gdac_pkg::DEV_ADDR_HI, a0, r};
	endfunction : aw
	task automatic cmd(input logic [7:0] b1, input logic k1, input logic [7:0] b2,
		input logic k2);
		st();
		sb(b1, k1);
		sb(b2, k2);
		sp();
	endtask : cmd
	task automatic wch(input logic [7:0] p, input logic [7:0] m, input logic [7:0] l);
		st();
		sb(aw(1'b0), 1'b1);
		sb(p, 1'b1);
		sb(m, 1'b1);
		sb(l, 1'b1);
		sp();
	endtask : wch
	initial begin
		v0 = 10'($urandom(32'h861d6ef0));
		v1 = 10'($urandom());
		v5 = 10'($urandom());
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		for (int i = 0; i < gdac_pkg::NCH; i++) see(i, 32'(gdac_pkg::MIDSCALE));
		nvp(1'b0, 5'h00, v0);
		nvp(1'b1, 5'h00, v1);
		nvp(1'b1, 5'h05, v5);
		for (int i = 0; i < 17; i++) nvp(1'b0, 5'h07, 10'h100 + 10'(i));
		for (int i = 0; i < 2; i++) begin
			a0 <= i[0];
			repeat (10) @(posedge clk_i);
			cmd(aw(1'b0), 1'b1, 8'h00, 1'b1);
			cmd({gdac_pkg::DEV_ADDR_HI, ~a0, 1'b0}, 1'b0, 8'h00, 1'b0);
		end
		wch(8'h02, 8'h01, 8'h23);
		see(2, 32'h200);
		wch(8'h03, 8'h82, 8'h34);
		see(2, 32'h123);
		see(3, 32'h234);
		st();
		sb(aw(1'b0), 1'b1);
		sb(8'h02, 1'b1);
		st();
		sb(aw(1'b1), 1'b1);
		rb(1'b1, 8'h01);
		rb(1'b0, 8'h23);
		sp();
		cmd(8'h00, 1'b1, 8'h07, 1'b0);
		see(3, 32'h234);
		cmd(8'h00, 1'b1, 8'h06, 1'b1);
		see(0, {22'h0, v0});
		see(3, 32'h200);
		see(7, 32'h10f);
		wch(8'h00, 8'h80, 8'h55);
		for (int i = 0; i < 3; i++) cmd(aw(1'b0), 1'b1, bad[i], 1'b0);
		repeat (3700) @(posedge clk_i);
		see(0, 32'h055);
		cmd(aw(1'b0), 1'b1, 8'h97, 1'b1);
		see(25, 32'h1);
		repeat (250) @(posedge clk_i);
		see(0, {22'h0, v0});
		// The pin then stays put for the rest of the run, so later acquires see a settled bank.
		bank <= 1'b1;
		repeat (20) @(posedge clk_i);
		see(0, {22'h0, v1});
		see(5, {22'h0, v5});
		see(7, 32'h200);
		wch(8'h05, 8'h81, 8'h11);
		wch(8'h06, 8'h81, 8'h22);
		see(5, 32'h111);
		cmd(aw(1'b0), 1'b1, 8'h45, 1'b1);
		repeat (3700) @(posedge clk_i);
		see(5, {22'h0, v5});
		see(6, 32'h122);
		st();
		ehs = 1'b1;
		sb({gdac_pkg::HS_CODE, 3'($urandom())}, 1'b0);
		see(24, 32'h1);
		st();
		sb(aw(1'b0), 1'b1);
		sb(8'h01, 1'b1);
		sb(8'h83, 1'b1);
		sb(8'hff, 1'b1);
		st();
		sb(aw(1'b0), 1'b1);
		see(24, 32'h1);
		ehs = 1'b0;
		sp();
		see(24, 32'h0);
		see(1, 32'h3ff);
		wrap_up();
	end
endmodule : gamma_dac_i2c_control_bench
`default_nettype wire
